// ==== src/snd_consts.svh ====
/*
 * Constants of the audio sender source and status register bank:
 * register offsets, field positions, reset values, frame counts.
 * Assumes inclusion by bare name from the sender package and module.
 */
`ifndef SND_CONSTS_SVH
`define SND_CONSTS_SVH

// --------------------------------------------------------------
// register offsets (7-bit host address)
// --------------------------------------------------------------
`define SND_ADDR_SUMMARY   7'h02
`define SND_ADDR_VALID     7'h07
`define SND_ADDR_BYPASS    7'h08
`define SND_ADDR_CUSRC     7'h09
`define SND_ADDR_STATUS    7'h0a
`define SND_ADDR_MASK      7'h0b
`define SND_ADDR_BUF_BASE  7'h40

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define SND_VALID_VBIT     0
`define SND_VALID_SLIPSEL  1
`define SND_BYP_SEL_LO     0
`define SND_BYP_COPYDIS    2
`define SND_CU_ORIGIN_LO   0
`define SND_CU_VORIGIN     2
`define SND_ST_DONE        0
`define SND_ST_SLIP        1
`define SND_MASK_DONE      0
`define SND_MASK_SLIP      1
`define SND_SUM_SENDER     0

// --------------------------------------------------------------
// reset values and sizes
// --------------------------------------------------------------
`define SND_RST_BYPSEL     2'h0
`define SND_RST_CUORIGIN   2'h0
`define SND_RST_BIT        1'h0
`define SND_BUF_BYTES      24
`define SND_HOST_BYTES     5'h0a
`define SND_FRAME_BITS     5'h10
`define SND_ADDR_BITS      5'h08

`endif

// ==== src/snd_pkg.sv ====
/*
 * Types of the audio sender source and status register bank.
 * Assumes snd_consts.svh is on the include path.
 */
`default_nettype none
`include "snd_consts.svh"

package snd_pkg;

  // cu_data_origin codes
  typedef enum logic [1:0] {
    SND_CU_NONE,
    SND_CU_HOST,
    SND_CU_DECODER,
    SND_CU_SPLIT
  } snd_origin_type;

  typedef logic [`SND_BUF_BYTES-1:0][7:0] snd_buf_type;

  // state kept on the system clock
  typedef struct packed {
    logic           vBitValue;
    logic           slipEventSelect;
    logic [1:0]     bypassSourceSelect;
    logic           bufferCopyDisable;
    snd_origin_type cuDataOrigin;
    logic           vBitOrigin;
    logic           bufferCopyDoneFlag;
    logic           sourceSlipFlag;
    logic           bufferCopyDoneEnable;
    logic           sourceSlipEnable;
    logic [3:0]     lineMeta;
    logic [3:0]     lineSync;
    logic           bypassOut;
    logic           frameMeta;
    logic           frameSync;
    logic           frameSeen;
    snd_buf_type    hostSideBuffer;
    snd_buf_type    outputSideBuffer;
    logic [7:0]     outData;
  } snd_core_type;

  // state kept on the host interface clock
  typedef struct packed {
    logic [4:0]     bitCnt;
    logic [15:0]    shift;
    logic [7:0]     misoShift;
    logic [47:0]    readMeta;
    logic [47:0]    readSync;
  } snd_link_type;

endpackage

`default_nettype wire

// ==== src/snd_sender_regs.sv ====
/*
 * Sender source and status register bank with its serial host port.
 * Assumes: host port frames of 16 bits, mode 0, chip select high for
 * at least four system clocks between frames; decoder buffer bytes,
 * block start and slip events arrive on the system clock.
 */
// Contract
// - two-bit bypass field routes line input 1..4 to bypass mux, 00 default.
// - cu origin 00 no update, 01 host writes, 10 decoder buffers.
// - cu origin 11: first ten bytes from host, rest from decoder.
// - v_bit_origin 0: validity bit comes from v_bit_value in 0x07.
// - v_bit_origin 1: validity bit passed from receiver with no latency.
// - copy completion sets done flag if copies enabled and done unmasked.
// - done flag drives irq_out_n low and sets summary flag in 0x02.
// - slip or block start event sets slip flag when slip unmasked.
// - slip_event_select in 0x07 picks slip or block start as source.
// - slip flag drives irq_out_n low and sets summary flag in 0x02.
// - status 0x0A read-only: bit1 slip, bit0 done, bits 7:2 zero.
// - copy disable suspends buffer copies; clearing resumes at next block.
// - done interrupt enable resets to 0, masking completion interrupt.
`default_nettype none
`include "snd_consts.svh"

module snd_sender_regs
  import snd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       hostSclk,
  input  wire logic       hostCsN,
  input  wire logic       hostMosi,
  output logic            hostMisoOut,
  output logic            hostMisoOe,
  input  wire logic [3:0] lineInput,
  output logic            bypassOut,
  input  wire logic       rxVBit,
  output logic            vBitOut,
  input  wire logic       decValid,
  input  wire logic [4:0] decIdx,
  input  wire logic [7:0] decData,
  input  wire logic       blockStart,
  input  wire logic       asyncSlip,
  input  wire logic       blockStartDet,
  input  wire logic [4:0] outIdx,
  output logic [7:0]      outData,
  output logic            irqOutN
);

  // --------------------------------------------------------------
  // decoding helpers
  // --------------------------------------------------------------
  // host writes may load this buffer byte
  function automatic logic hostLoads(snd_origin_type o, logic [4:0] i);
    hostLoads = (o == SND_CU_HOST) ||
                (o == SND_CU_SPLIT && i < `SND_HOST_BYTES);
  endfunction

  // decoder-side buffer may load this buffer byte
  function automatic logic decLoads(snd_origin_type o, logic [4:0] i);
    decLoads = (o == SND_CU_DECODER) ||
               (o == SND_CU_SPLIT && i >= `SND_HOST_BYTES);
  endfunction

  // pick a readable byte from the synchronised register image
  function automatic logic [7:0] readSel(logic [6:0] a, logic [47:0] img);
    case (a)
      `SND_ADDR_SUMMARY: readSel = img[7:0];
      `SND_ADDR_VALID:   readSel = img[15:8];
      `SND_ADDR_BYPASS:  readSel = img[23:16];
      `SND_ADDR_CUSRC:   readSel = img[31:24];
      `SND_ADDR_STATUS:  readSel = img[39:32];
      `SND_ADDR_MASK:    readSel = img[47:40];
      default:           readSel = 8'h00;
    endcase
  endfunction

  snd_core_type cReg;
  snd_core_type cNext;
  snd_link_type lReg;
  snd_link_type lNext;
  logic [47:0]  readImage;
  logic         summary;
  logic         frameEvt;
  logic         frameRead;
  logic [6:0]   frameAddr;
  logic [7:0]   frameData;
  logic [4:0]   bufIdx;
  logic         slipEvt;
  logic         statusRead;
  logic         copyNow;

  // --------------------------------------------------------------
  // register image seen by the host port
  // --------------------------------------------------------------
  // summary and interrupt follow the sticky flags
  assign summary = cReg.bufferCopyDoneFlag | cReg.sourceSlipFlag;
  assign irqOutN = ~summary;
  assign readImage = {
    6'h00, cReg.sourceSlipEnable, cReg.bufferCopyDoneEnable,
    6'h00, cReg.sourceSlipFlag, cReg.bufferCopyDoneFlag,
    5'h00, cReg.vBitOrigin, cReg.cuDataOrigin,
    5'h00, cReg.bufferCopyDisable, cReg.bypassSourceSelect,
    6'h00, cReg.slipEventSelect, cReg.vBitValue,
    7'h00, summary
  };

  // validity bit has no register in its path
  assign vBitOut = cReg.vBitOrigin ? rxVBit : cReg.vBitValue;
  assign bypassOut = cReg.bypassOut;
  assign outData = cReg.outData;

  // --------------------------------------------------------------
  // host port, host interface clock domain
  // --------------------------------------------------------------
  // miso drives only inside a frame
  assign hostMisoOut = lReg.misoShift[7];
  assign hostMisoOe = ~hostCsN;

  // shift in command, address and data; load read byte after address
  always_comb begin
    lNext = lReg;
    lNext.readMeta = readImage;
    lNext.readSync = lReg.readMeta;
    if (lReg.bitCnt < `SND_FRAME_BITS) begin
      lNext.shift = {lReg.shift[14:0], hostMosi};
      lNext.bitCnt = lReg.bitCnt + 5'h01;
    end
    if (lReg.bitCnt == `SND_ADDR_BITS - 5'h01) begin
      lNext.misoShift = readSel({lReg.shift[5:0], hostMosi},
                                lReg.readSync);
    end else if (lReg.bitCnt >= `SND_ADDR_BITS &&
                 lReg.bitCnt < `SND_FRAME_BITS) begin
      lNext.misoShift = {lReg.misoShift[6:0], 1'b0};
    end
  end

  // chip select high ends the frame and clears the bit count
  always_ff @(posedge hostSclk or posedge hostCsN) begin
    if (hostCsN) begin
      lReg.bitCnt <= 5'h00;
    end else begin
      lReg <= lNext;
    end
  end

  // --------------------------------------------------------------
  // frame decode on the system clock
  // --------------------------------------------------------------
  // frame word is stable while its done level is high
  assign frameEvt = cReg.frameSync & ~cReg.frameSeen;
  assign frameRead = lReg.shift[15];
  assign frameAddr = lReg.shift[14:8];
  assign frameData = lReg.shift[7:0];
  assign bufIdx = 5'(frameAddr - `SND_ADDR_BUF_BASE);
  assign statusRead = frameEvt & frameRead &
                      (frameAddr == `SND_ADDR_STATUS);
  assign slipEvt = cReg.slipEventSelect ? blockStartDet : asyncSlip;
  assign copyNow = blockStart & ~cReg.bufferCopyDisable;

  // --------------------------------------------------------------
  // system clock state
  // --------------------------------------------------------------
  // register writes, buffer loads, block copies and sticky flags
  always_comb begin
    cNext = cReg;
    cNext.lineMeta = lineInput;
    cNext.lineSync = cReg.lineMeta;
    cNext.bypassOut = cReg.lineSync[cReg.bypassSourceSelect];
    cNext.frameMeta = (lReg.bitCnt == `SND_FRAME_BITS);
    cNext.frameSync = cReg.frameMeta;
    cNext.frameSeen = cReg.frameSync;
    if (frameEvt && !frameRead) begin
      case (frameAddr)
        `SND_ADDR_VALID: begin
          cNext.vBitValue = frameData[`SND_VALID_VBIT];
          cNext.slipEventSelect = frameData[`SND_VALID_SLIPSEL];
        end
        `SND_ADDR_BYPASS: begin
          cNext.bypassSourceSelect =
            frameData[`SND_BYP_SEL_LO +: 2];
          cNext.bufferCopyDisable = frameData[`SND_BYP_COPYDIS];
        end
        `SND_ADDR_CUSRC: begin
          cNext.cuDataOrigin =
            snd_origin_type'(frameData[`SND_CU_ORIGIN_LO +: 2]);
          cNext.vBitOrigin = frameData[`SND_CU_VORIGIN];
        end
        `SND_ADDR_MASK: begin
          cNext.bufferCopyDoneEnable = frameData[`SND_MASK_DONE];
          cNext.sourceSlipEnable = frameData[`SND_MASK_SLIP];
        end
        default: begin
          if (frameAddr >= `SND_ADDR_BUF_BASE &&
              bufIdx < 5'(`SND_BUF_BYTES) &&
              hostLoads(cReg.cuDataOrigin, bufIdx)) begin
            cNext.hostSideBuffer[bufIdx] = frameData;
          end
        end
      endcase
    end
    if (decValid && decIdx < 5'(`SND_BUF_BYTES) &&
        decLoads(cReg.cuDataOrigin, decIdx)) begin
      cNext.hostSideBuffer[decIdx] = decData;
    end
    if (copyNow) begin
      cNext.outputSideBuffer = cReg.hostSideBuffer;
    end
    cNext.outData = (outIdx < 5'(`SND_BUF_BYTES)) ?
                    cReg.outputSideBuffer[outIdx] : 8'h00;
    // a status read clears, an event in the same cycle wins
    if (statusRead) begin
      cNext.bufferCopyDoneFlag = 1'b0;
      cNext.sourceSlipFlag = 1'b0;
    end
    if (copyNow && cReg.bufferCopyDoneEnable) begin
      cNext.bufferCopyDoneFlag = 1'b1;
    end
    if (slipEvt && cReg.sourceSlipEnable) begin
      cNext.sourceSlipFlag = 1'b1;
    end
  end

  // synchronous reset to documented defaults
  always_ff @(posedge clk) begin
    if (srst) begin
      cReg <= '0;
      cReg.bypassSourceSelect <= `SND_RST_BYPSEL;
      cReg.cuDataOrigin <= snd_origin_type'(`SND_RST_CUORIGIN);
      cReg.bufferCopyDisable <= `SND_RST_BIT;
      cReg.bufferCopyDoneEnable <= `SND_RST_BIT;
      cReg.sourceSlipEnable <= `SND_RST_BIT;
    end else begin
      cReg <= cNext;
    end
  end

endmodule

`default_nettype wire

// ==== tb/snd_host_model.sv ====
/* serial host controller model: 16-bit frames, mode 0, msb first.
   assumes the device samples on link clock rise; 30 ns link period. */
`default_nettype none
module snd_host_model (
  output logic     hostSclk,
  output logic     hostCsN,
  output logic     hostMosi,
  input wire logic hostMisoOut
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    hostSclk = 1'b0;
    hostCsN = 1'b0;
    hostMosi = 1'b1;
    // a select edge clears the unreset frame counter at start
    #5 hostCsN = 1'b1;
  end
  // one frame; the link clock stands still outside it
  task automatic xfer(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    hostCsN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      hostMosi = w[i];
      #15;
      if (i < 8) r[i] = hostMisoOut; // read byte, msb first
      hostSclk = 1'b1;
      #15 hostSclk = 1'b0;
    end
    #15 hostCsN = 1'b1;
    hostMosi = ~w[0]; // released line shows no stale bit
    #150; // idle gap before the next frame
  endtask
endmodule
`default_nettype wire

// ==== tb/snd_sender_regs_checker.sv ====
/* port checker of the sender register bank.
   assumes binding to snd_sender_regs, system clock domain only. */
`default_nettype none
module snd_sender_regs_checker (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       hostCsN,
  input wire logic       hostMisoOe,
  input wire logic       blockStart,
  input wire logic       asyncSlip,
  input wire logic       blockStartDet,
  input wire logic [4:0] outIdx,
  input wire logic [7:0] outData,
  input wire logic       bypassOut,
  input wire logic       irqOutN
);
  default clocking @(posedge clk); endclocking
  a_reset_irq_idle: assert property (disable iff (1'b0)
    srst |=> irqOutN) else $error("irq active after reset");
  a_reset_bypass_low: assert property (disable iff (1'b0)
    srst |=> !bypassOut) else $error("bypass not cleared by reset");
  a_irq_has_cause: assert property (disable iff (srst)
    $fell(irqOutN) |-> $past(blockStart | asyncSlip | blockStartDet))
    else $error("irq fell without an event");
  a_irq_holds: assert property (disable iff (srst)
    !irqOutN && hostCsN && $past(hostCsN, 6) |=> !irqOutN)
    else $error("irq released without a read");
  a_irq_clear_read: assert property (disable iff (srst)
    $rose(irqOutN) |-> $past(srst) || $past(hostCsN))
    else $error("irq released during a frame");
  a_miso_enable: assert property (hostMisoOe == !hostCsN)
    else $error("miso enable differs from select");
  a_out_stable: assert property (disable iff (srst)
    !blockStart && !$past(blockStart) && !$past(srst) && $stable(outIdx)
    |=> $stable(outData)) else $error("output buffer changed off block");
  a_out_range: assert property (disable iff (srst)
    outIdx >= 5'd24 |=> outData == 8'h00)
    else $error("byte beyond buffer not zero");
endmodule
bind snd_sender_regs snd_sender_regs_checker snd_sender_regs_checker_inst (
  .clk(clk), .srst(srst), .hostCsN(hostCsN), .hostMisoOe(hostMisoOe),
  .blockStart(blockStart), .asyncSlip(asyncSlip),
  .blockStartDet(blockStartDet), .outIdx(outIdx), .outData(outData),
  .bypassOut(bypassOut), .irqOutN(irqOutN));
`default_nettype wire

// ==== tb/snd_sender_regs_tb_top.sv ====
/* self-checking bench of the sender register bank.
   assumes the host model for frames; events driven on the system clock. */
`default_nettype none
module snd_sender_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk = 1'b0, srst = 1'b1;
  logic       hostSclk, hostCsN, hostMosi, hostMisoOut, hostMisoOe;
  logic [3:0] lineInput;
  logic       bypassOut, rxVBit, vBitOut, decValid, irqOutN;
  logic       blockStart, asyncSlip, blockStartDet;
  logic [4:0] decIdx, outIdx;
  logic [7:0] decData, outData, h9, h10, ia;
  logic [7:0] sa [2];
  logic [7:0] sb [2];
  int         failures = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  snd_host_model snd_host_model_inst (.hostSclk(hostSclk),
    .hostCsN(hostCsN), .hostMosi(hostMosi), .hostMisoOut(hostMisoOut));
  snd_sender_regs snd_sender_regs_inst (.clk(clk), .srst(srst),
    .hostSclk(hostSclk), .hostCsN(hostCsN), .hostMosi(hostMosi),
    .hostMisoOut(hostMisoOut), .hostMisoOe(hostMisoOe),
    .lineInput(lineInput), .bypassOut(bypassOut), .rxVBit(rxVBit),
    .vBitOut(vBitOut), .decValid(decValid), .decIdx(decIdx),
    .decData(decData), .blockStart(blockStart), .asyncSlip(asyncSlip),
    .blockStartDet(blockStartDet), .outIdx(outIdx), .outData(outData),
    .irqOutN(irqOutN));
  // ----------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    snd_host_model_inst.xfer({1'b0, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    snd_host_model_inst.xfer({1'b1, a, 8'h00}, r);
    chk(r, e);
  endtask
  // one-cycle pulse of {blockStart, asyncSlip, blockStartDet}
  task automatic ev(input logic [2:0] k);
    tick(1);
    {blockStart, asyncSlip, blockStartDet} = k;
    tick(1);
    {blockStart, asyncSlip, blockStartDet} = 3'h0;
    tick(2);
  endtask
  task automatic db(input logic [4:0] i, input logic [7:0] d);
    tick(1);
    {decValid, decIdx, decData} = {1'b1, i, d};
    tick(1);
    decValid = 1'b0;
  endtask
  task automatic ob(input logic [4:0] i, input logic [7:0] e);
    tick(1);
    outIdx = i;
    tick(2);
    chk(outData, e);
  endtask
  task automatic close_out;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    close_out();
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    {lineInput, rxVBit, decValid, decIdx, decData} = '0;
    {blockStart, asyncSlip, blockStartDet, outIdx} = '0;
    tick(3);
    srst = 1'b0;
    foreach (sa[i]) rd(7'h0b, 8'h00);
    rd(7'h30, 8'h00);
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'h00);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      wr(7'h08, 8'(s));
      tick(1);
      lineInput = 4'h1 << s;
      tick(5);
      chk({7'h0, bypassOut}, 8'h01);
      lineInput = ~(4'h1 << s);
      tick(5);
      chk({7'h0, bypassOut}, 8'h00);
    end
    wr(7'h07, 8'h01);
    tick(1);
    chk({7'h0, vBitOut}, 8'h01);
    wr(7'h09, 8'h04);
    for (int v = 0; v < 2; v++) begin
      rxVBit = v[0];
      #1 chk({7'h0, vBitOut}, 8'(v));
    end
    $display("test mux done");
    wr(7'h0b, 8'h01);
    {h9, h10} = 16'h0;
    for (int o = 0; o < 4; o++) begin
      wr(7'h09, 8'(o));
      wr(7'h49, 8'h90 + 8'(o));
      wr(7'h4a, 8'ha0 + 8'(o));
      db(5'd9, 8'hb0 + 8'(o));
      db(5'd10, 8'hc0 + 8'(o));
      if (o == 1 || o == 3) h9 = 8'h90 + 8'(o);
      if (o == 2) h9 = 8'hb2;
      if (o == 1) h10 = 8'ha1;
      if (o > 1) h10 = 8'hc0 + 8'(o);
      ev(3'h4);
      chk({7'h0, irqOutN}, 8'h00);
      ob(5'd9, h9);
      ob(5'd10, h10);
      rd(7'h02, 8'h01);
      rd(7'h0a, 8'h01);
      rd(7'h0a, 8'h00);
    end
    wr(7'h08, 8'h04);
    wr(7'h49, 8'h55);
    ev(3'h4);
    ob(5'd9, 8'h93);
    rd(7'h0a, 8'h00);
    wr(7'h08, 8'h00);
    ev(3'h4);
    ob(5'd9, 8'h55);
    ob(5'd24, 8'h00);
    rd(7'h0a, 8'h01);
    wr(7'h0b, 8'h00);
    ev(3'h7);
    chk({7'h0, irqOutN}, 8'h01);
    rd(7'h0a, 8'h00);
    $display("test buffer done");
    wr(7'h0b, 8'h02);
    for (int s = 0; s < 2; s++) begin
      wr(7'h07, {6'h0, s[0], 1'b0});
      ev(3'h2);
      ia = {6'h0, ~irqOutN, 1'b0};
      snd_host_model_inst.xfer({1'b1, 7'h0a, 8'h00}, sa[s]);
      chk(ia, sa[s]);
      ev(3'h1);
      snd_host_model_inst.xfer({1'b1, 7'h0a, 8'h00}, sb[s]);
      chk(sa[s] | sb[s], 8'h02);
      chk(sa[s] ^ sb[s], 8'h02);
    end
    chk(sa[0] ^ sa[1], 8'h02);
    $display("test slip done");
    close_out();
  end
endmodule
`default_nettype wire
